// *** copy_cmd_pkg.sv ***
// Package: header fields, opcode map, register map and power-image layout
`default_nettype none
package copy_cmd_pkg;
   // ---------------------------------------------------------------
   // Header fields
   // ---------------------------------------------------------------
   localparam int CLASS_HI   = 31;
   localparam int CLASS_LO   = 29;
   localparam int OP2D_HI    = 28;
   localparam int OP2D_LO    = 22;
   localparam int DEP2D_HI   = 21;
   localparam int DEP2D_LO   = 9;
   localparam int LEN2D_HI   = 8;
   localparam int LEN2D_LO   = 0;
   localparam int MIOP_HI    = 28;
   localparam int MIOP_LO    = 23;
   localparam int MILEN_HI   = 5;
   localparam int MILEN_LO   = 0;
   localparam logic [2:0] CLASS_HOST = 3'h0;
   localparam logic [2:0] CLASS_BLT  = 3'h2;
   // Host interface opcode groups (upper two bits of the six-bit opcode)
   localparam logic [5:0] MI_NOP_OP    = 6'h00;
   localparam logic [1:0] MI_GRP_ONE   = 2'h0;
   localparam logic [1:0] MI_GRP_MULTI = 2'h1;
   localparam logic [1:0] MI_GRP_STORE = 2'h2;
   localparam logic [1:0] MI_GRP_RING  = 2'h3;
   localparam logic [5:0] MI_LRI_OP    = 6'h22;
   localparam logic [5:0] MI_BBEND_OP  = 6'h0a;
   // 2D opcode map
   localparam logic [6:0] OP_COORD_SETUP = 7'h01;
   localparam logic [6:0] OP_CLIP_SETUP  = 7'h03;
   localparam logic [6:0] OP_MONO_SETUP  = 7'h11;
   localparam logic [6:0] OP_XFER_A_LO   = 7'h24;
   localparam logic [6:0] OP_XFER_A_HI   = 7'h26;
   localparam logic [6:0] OP_XFER_B      = 7'h31;
   localparam logic [6:0] OP_XFER_C_LO   = 7'h40;
   localparam logic [6:0] OP_XFER_C_HI   = 7'h59;
   localparam logic [6:0] OP_XFER_D_LO   = 7'h71;
   localparam logic [6:0] OP_XFER_D_HI   = 7'h77;
   localparam logic [6:0] OP_HOLE_LO     = 7'h45;
   localparam logic [6:0] OP_HOLE_HI     = 7'h47;
   localparam logic [6:0] OP_HOLE2_LO    = 7'h49;
   localparam logic [6:0] OP_HOLE2_HI    = 7'h4f;
   localparam logic [6:0] OP_LINEAR_A    = 7'h40;
   localparam logic [6:0] OP_LINEAR_B    = 7'h43;
   // Chroma-key transfers in the immediate range carry no inline tail
   localparam logic [6:0] OP_CHROMA_SRC  = 7'h73;
   localparam logic [6:0] OP_CHROMA_PAT  = 7'h76;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [19:0] MMIO_LO        = 20'h22000;
   localparam logic [19:0] MMIO_HI        = 20'h224ff;
   localparam logic [19:0] WRITE_OPEN_PFX = 20'h22000;
   localparam logic [19:0] WRITE_OPEN_MSK = 20'hfff00;
   localparam logic [19:0] BUS_AGENT_ADDR = 20'h220a0;
   localparam logic [19:0] SWCTRL_BASE    = 20'h22200;
   localparam logic [19:0] GPR_BASE       = 20'h22600;
   localparam int          OPEN_DWORDS    = 32;
   localparam logic [19:0] BLOCK_SPAN     = 20'h00080;
   localparam int          REG_IDX_HI     = 6;
   localparam int          REG_IDX_LO     = 2;
   localparam logic [31:0] REG_RESET      = 32'h0000_0000;
   // ---------------------------------------------------------------
   // Power context image layout (dword offsets)
   // ---------------------------------------------------------------
   localparam int          FRONT_DWORDS = 192;
   localparam logic [7:0]  PI_NOOP0     = 8'hd0;
   localparam logic [7:0]  PI_LRI       = 8'hd1;
   localparam logic [7:0]  PI_AGENT_A   = 8'hd4;
   localparam logic [7:0]  PI_AGENT_D   = 8'hd5;
   localparam logic [7:0]  PI_BBEND     = 8'hdf;
   localparam logic [31:0] LRI_HEADER   = 32'h1100_1003;
   localparam logic [31:0] NOOP_DW      = 32'h0000_0000;
   localparam logic [31:0] BBEND_DW     = 32'h0500_0000;
   // Pitch granularity in bytes for untiled colour operands
   localparam logic [3:0]  PITCH_BYTES  = 4'h4;

   typedef enum logic [2:0] {
      KIND_NONE, KIND_HOST, KIND_SETUP, KIND_XFER, KIND_RESERVED
   } cmd_kind_e;

   // Decoded header, presented to the engine
   typedef struct packed {
      logic        valid;
      cmd_kind_e   kind;
      logic        to_engine;
      logic [6:0]  opcode;
      logic [12:0] dep_data;
      logic [8:0]  dw_count;
      logic [1:0]  host_group;
      logic        inline_data;
   } hdr_dec_s;

   // Clipped transfer rectangle
   typedef struct packed {
      logic        valid;
      logic        skip;
      logic [15:0] x1;
      logic [15:0] y1;
      logic [15:0] x2;
      logic [15:0] y2;
      logic [17:0] pitch_bytes;
   } rect_s;
endpackage
`default_nettype wire

// *** copy_cmd_header_decoder.sv ***
// Command header decoder, register writes, power image and rectangle rules
//
// Overview of operation
// RULE_01: Header bits 31:29 pick host or blit class
// RULE_02: Blit header: opcode, data, dword count fields
// RULE_03: Host opcodes grouped by upper nibble; the code groups by the upper two bits of the six-bit opcode
// RULE_04: Multi-dword host length from bits 5:0
// RULE_05: Opcodes 01h,03h,11h only load setup state
// RULE_06: Listed opcode ranges transfer; others reserved
// RULE_07: Fixed length, some with inline data tail
// RULE_08: Non-secure immediate loads may write 22XX
// RULE_09: Open blocks at 22600h and 22200h, 32 dwords
// RULE_10: Power image starts with 192 front dwords
// RULE_11: Back image: noop, load header, agent mode, end
// RULE_12: Save and reload state on context switch; the code reloads only the agent mode register
// RULE_13: Immediate operands come from the stream
// RULE_14: Operands from aperture or cacheable memory
// RULE_15: Untiled colour pitch counted in dwords
// RULE_16: First corner inclusive, second corner exclusive
// RULE_17: Software keeps source and clip non-negative
// RULE_18: Unclipped negative destination clamps to zero
// RULE_19: Linear blit with zero size does nothing
// RULE_20: Claim only register cycles in 22000h-224FFh
// RULE_21: Header routes command to engine or parser
// RULE_22: Reserved header flagged, no memory access
`default_nettype none
module copy_cmd_header_decoder
   import copy_cmd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   // Command dword stream from the fetch FIFO
   input  wire logic        cmd_valid,
   input  wire logic [31:0] cmd_dword,
   input  wire logic        cmd_nonsecure,
   output logic             cmd_ready,
   // Register cycle port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [19:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_priv,
   output logic             reg_claim,
   output logic [31:0]      reg_rdata,
   // Decoded header and inline data
   output hdr_dec_s         hdr_out,
   output logic             inline_valid,
   output logic [31:0]      inline_dword,
   output logic             mem_fetch_en,
   output logic             reserved_flag,
   // Rectangle input for a transfer
   input  wire logic        rect_load,
   input  wire logic        clip_en,
   input  wire logic        operand_tiled,
   input  wire logic        operand_mono,
   input  wire logic [15:0] pitch_dw,
   input  wire logic signed [15:0] dx1,
   input  wire logic signed [15:0] dy1,
   input  wire logic signed [15:0] dx2,
   input  wire logic signed [15:0] dy2,
   output rect_s            rect_out,
   // Power image readout (dword index into this engine's region)
   input  wire logic        img_rd,
   input  wire logic [7:0]  img_idx,
   input  wire logic [31:0] front_ctx,
   output logic             img_valid,
   output logic [31:0]      img_dword,
   // Context restore of the agent mode register
   input  wire logic        ctx_restore,
   input  wire logic [31:0] ctx_agent_mode
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_HEADER, ST_BODY, ST_INLINE} parse_e;

   typedef struct packed {
      parse_e      pst;
      logic [8:0]  remain;
      logic        ready;
      hdr_dec_s    hdr;
      logic        inl_v;
      logic [31:0] inl_d;
      logic        fetch;
      logic        resv;
      logic        claim;
      logic [31:0] rdata;
      logic [31:0] agent_mode;
      rect_s       rect;
      logic        img_v;
      logic [31:0] img_d;
   } state_s;

   state_s st;
   state_s next_st;
   logic [31:0] swctrl [OPEN_DWORDS];
   logic [31:0] gpr    [OPEN_DWORDS];
   logic [4:0]  widx;
   logic        in_sw;
   logic        in_gpr;

   assign widx   = reg_addr[REG_IDX_HI:REG_IDX_LO];
   assign in_sw  = (reg_addr >= SWCTRL_BASE) && (reg_addr < SWCTRL_BASE + BLOCK_SPAN);
   assign in_gpr = (reg_addr >= GPR_BASE) && (reg_addr < GPR_BASE + BLOCK_SPAN);

   // ---------------------------------------------------------------
   // Header classification
   // ---------------------------------------------------------------
   function automatic hdr_dec_s decode(input logic [31:0] h);
      hdr_dec_s d;
      logic [6:0] op;
      d = '0;
      op = h[OP2D_HI:OP2D_LO];
      d.valid = 1'b1;
      // RULE_01 class select
      if (h[CLASS_HI:CLASS_LO] == CLASS_BLT) begin
         // RULE_02 blit fields
         d.opcode   = op;
         d.dep_data = h[DEP2D_HI:DEP2D_LO];
         d.dw_count = h[LEN2D_HI:LEN2D_LO];
         // RULE_05 setup opcodes
         if (op == OP_COORD_SETUP || op == OP_CLIP_SETUP || op == OP_MONO_SETUP) begin
            d.kind = KIND_SETUP;
         // RULE_06 transfer ranges
         end else if ((op >= OP_XFER_A_LO && op <= OP_XFER_A_HI) || op == OP_XFER_B ||
                      (op >= OP_XFER_C_LO && op <= OP_XFER_C_HI &&
                       !(op >= OP_HOLE_LO && op <= OP_HOLE_HI) &&
                       !(op >= OP_HOLE2_LO && op <= OP_HOLE2_HI)) ||
                      (op >= OP_XFER_D_LO && op <= OP_XFER_D_HI)) begin
            d.kind = KIND_XFER;
         end else begin
            d.kind = KIND_RESERVED;
         end
         // RULE_13 immediate forms carry inline data
         d.inline_data = (op == OP_XFER_B) || (op >= OP_XFER_D_LO && op <= OP_XFER_D_HI &&
                          op != OP_CHROMA_SRC && op != OP_CHROMA_PAT);
         // RULE_21 engine route
         d.to_engine = (d.kind != KIND_RESERVED);
      end else if (h[CLASS_HI:CLASS_LO] == CLASS_HOST) begin
         // RULE_03 host groups
         d.kind       = KIND_HOST;
         d.opcode     = {1'b0, h[MIOP_HI:MIOP_LO]};
         d.host_group = h[MIOP_HI:MIOP_HI-1];
         // RULE_04 multi-dword length
         if (h[MIOP_HI:MIOP_LO] != MI_NOP_OP && d.host_group != MI_GRP_ONE)
            d.dw_count = {3'h0, h[MILEN_HI:MILEN_LO]};
         d.to_engine = 1'b0;
      end else begin
         // RULE_22 reserved class
         d.kind = KIND_RESERVED;
      end
      return d;
   endfunction

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      hdr_dec_s d;
      logic signed [15:0] cx1;
      logic signed [15:0] cy1;
      d = decode(cmd_dword);
      cx1 = dx1;
      cy1 = dy1;
      next_st = st;
      next_st.hdr.valid = 1'b0;
      next_st.inl_v = 1'b0;
      next_st.img_v = 1'b0;
      next_st.claim = 1'b0;
      next_st.rect.valid = 1'b0;
      next_st.ready = 1'b1;
      // Command stream parsing
      if (cmd_valid && st.ready) begin
         case (st.pst)
            ST_HEADER: begin
               next_st.hdr = d;
               // RULE_22 flag and suppress fetch
               next_st.resv  = st.resv | (d.kind == KIND_RESERVED);
               next_st.fetch = (d.kind == KIND_XFER);
               // RULE_07 body length from the header count
               next_st.remain = d.dw_count;
               if (d.dw_count != 9'h0 && d.kind != KIND_RESERVED)
                  next_st.pst = d.inline_data ? ST_INLINE : ST_BODY;
            end
            ST_BODY, ST_INLINE: begin
               // RULE_13 inline operands passed from the stream
               next_st.inl_v = 1'b1;
               next_st.inl_d = cmd_dword;
               next_st.remain = st.remain - 9'h1;
               if (st.remain == 9'h1)
                  next_st.pst = ST_HEADER;
            end
            default: next_st.pst = ST_HEADER;
         endcase
      end
      // RULE_20 claim window
      if ((reg_wr || reg_rd) && reg_addr >= MMIO_LO && reg_addr <= MMIO_HI) begin
         next_st.claim = 1'b1;
         next_st.rdata = REG_RESET;
         if (reg_rd) begin
            if (reg_addr == BUS_AGENT_ADDR)
               next_st.rdata = st.agent_mode;
            else if (in_sw)
               next_st.rdata = swctrl[widx];
            else if (in_gpr)
               next_st.rdata = gpr[widx];
            else if (reg_addr == MMIO_LO)
               next_st.rdata = {28'h0, st.resv, st.fetch, st.pst};
         end
         // RULE_08 unprotected 22XX write
         if (reg_wr && reg_addr == BUS_AGENT_ADDR &&
             (reg_priv || (reg_addr & WRITE_OPEN_MSK) == WRITE_OPEN_PFX))
            next_st.agent_mode = reg_wdata;
         // Writing the status word clears the reserved flag unless a reserved header is taken in the same cycle
         if (reg_wr && reg_addr == MMIO_LO)
            next_st.resv = st.ready && cmd_valid && st.pst == ST_HEADER && d.kind == KIND_RESERVED;
      end
      // Open-block writes outside the window land but are never claimed
      // RULE_12 context restore reloads the saved agent mode register
      if (ctx_restore)
         next_st.agent_mode = ctx_agent_mode;
      // Rectangle conventions
      if (rect_load) begin
         // RULE_18 clamp negatives when unclipped
         if (!clip_en && cx1 < 0)
            cx1 = '0;
         if (!clip_en && cy1 < 0)
            cy1 = '0;
         next_st.rect.valid = 1'b1;
         next_st.rect.x1 = cx1;
         next_st.rect.y1 = cy1;
         next_st.rect.x2 = (!clip_en && dx2 < 0) ? 16'h0 : dx2;
         next_st.rect.y2 = (!clip_en && dy2 < 0) ? 16'h0 : dy2;
         // RULE_16 exclusive second corner gives empty when x2<=x1
         // RULE_19 zero size suppresses access
         // Compare as signed so a negative corner under clipping orders right
         next_st.rect.skip = ($signed(next_st.rect.x2) <= $signed(next_st.rect.x1)) ||
                             ($signed(next_st.rect.y2) <= $signed(next_st.rect.y1));
         // RULE_15 dword pitch for untiled colour
         next_st.rect.pitch_bytes = (!operand_tiled && !operand_mono) ?
                                    {pitch_dw, 2'h0} : {2'h0, pitch_dw};
         // RULE_14 fetch only when rectangle non-empty
         if (next_st.rect.skip)
            next_st.fetch = 1'b0;
      end
      // Power image readout
      if (img_rd) begin
         next_st.img_v = 1'b1;
         // RULE_10 front context first
         if (img_idx < 8'(FRONT_DWORDS))
            next_st.img_d = front_ctx;
         else begin
            // RULE_11 back-end layout
            case (img_idx)
               PI_LRI:     next_st.img_d = LRI_HEADER;
               PI_AGENT_A: next_st.img_d = {12'h0, BUS_AGENT_ADDR};
               PI_AGENT_D: next_st.img_d = st.agent_mode;
               PI_BBEND:   next_st.img_d = BBEND_DW;
               default:    next_st.img_d = NOOP_DW;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // RULE_09 open register blocks
   always_ff @(posedge clk) begin
      if (ce && reg_wr && in_sw)
         swctrl[widx] <= reg_wdata;
      if (ce && reg_wr && in_gpr)
         gpr[widx] <= reg_wdata;
   end

   assign cmd_ready     = st.ready;
   assign reg_claim     = st.claim;
   assign reg_rdata     = st.rdata;
   assign hdr_out       = st.hdr;
   assign inline_valid  = st.inl_v;
   assign inline_dword  = st.inl_d;
   assign mem_fetch_en  = st.fetch;
   assign reserved_flag = st.resv;
   assign rect_out      = st.rect;
   assign img_valid     = st.img_v;
   assign img_dword     = st.img_d;
endmodule
`default_nettype wire

// *** cmd_source.sv ***
// Model of the driver-written command buffer feeding the decoder
`default_nettype none
module cmd_source (
   input  wire logic        clk,
   input  wire logic        ready,
   input  wire logic        slow,
   output logic             valid,
   output logic [31:0]      dword
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] q [$];
   logic        taken = 1'h0;
   initial begin
      valid = 1'h0;
      dword = 32'h0;
   end
   // Note the edge at which the decoder took a dword
   always @(posedge clk) taken <= valid && ready;
   always @(negedge clk) begin
      if (taken) void'(q.pop_front());
      if (q.size() > 0 && !(slow && taken)) begin
         valid <= 1'h1;
         dword <= q[0];
      end else begin
         valid <= 1'h0;
         dword <= ~dword; // Released bus alternates between the last word and its inverse
      end
   end
endmodule
`default_nettype wire

// *** copy_cmd_header_decoder_checker.sv ***
// Port assertions for the command header decoder
`default_nettype none
module copy_cmd_header_decoder_checker
   import copy_cmd_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic [31:0] cmd_dword,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [19:0] reg_addr,
   input wire logic        reg_claim,
   input wire hdr_dec_s    hdr_out,
   input wire logic        mem_fetch_en,
   input wire logic        reserved_flag,
   input wire logic        rect_load,
   input wire logic        clip_en,
   input wire logic signed [15:0] dx1,
   input wire logic signed [15:0] dx2,
   input wire rect_s       rect_out,
   input wire logic        img_rd,
   input wire logic [7:0]  img_idx,
   input wire logic [31:0] front_ctx,
   input wire logic        img_valid,
   input wire logic [31:0] img_dword
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_class_blit: assert property (
      hdr_out.valid && hdr_out.kind inside {KIND_SETUP, KIND_XFER}
      |-> $past(cmd_dword[31:29]) == CLASS_BLT) else $error("blit kind from wrong class");
   a_blit_fields: assert property (
      hdr_out.valid && hdr_out.kind != KIND_RESERVED && $past(cmd_dword[31:29]) == CLASS_BLT
      |-> hdr_out.opcode == $past(cmd_dword[28:22]) && hdr_out.dw_count == $past(cmd_dword[8:0])
      && hdr_out.dep_data == $past(cmd_dword[21:9])) else $error("blit fields wrong");
   a_host_route: assert property (
      hdr_out.valid && hdr_out.kind == KIND_HOST
      |-> !hdr_out.to_engine && $past(cmd_dword[31:29]) == CLASS_HOST) else $error("host route");
   a_setup_idle: assert property (
      hdr_out.valid && hdr_out.kind == KIND_SETUP |-> !mem_fetch_en) else $error("setup fetches");
   a_xfer_fetch: assert property (
      hdr_out.valid && hdr_out.kind == KIND_XFER |-> mem_fetch_en) else $error("no fetch");
   a_resv_flag: assert property (
      hdr_out.valid && hdr_out.kind == KIND_RESERVED |-> reserved_flag && !mem_fetch_en)
      else $error("reserved header not flagged");
   a_claim_in: assert property (
      (reg_rd || reg_wr) && reg_addr >= MMIO_LO && reg_addr <= MMIO_HI |=> reg_claim)
      else $error("window cycle not claimed");
   a_claim_out: assert property (
      reg_claim |-> $past((reg_rd || reg_wr) && reg_addr >= MMIO_LO && reg_addr <= MMIO_HI))
      else $error("stray claim");
   a_img_front: assert property (
      img_rd && img_idx < 8'hc0 |=> img_valid && img_dword == $past(front_ctx))
      else $error("front image word wrong");
   a_img_lri: assert property (
      img_rd && img_idx == PI_LRI |=> img_valid && img_dword == LRI_HEADER)
      else $error("image load header wrong");
   a_rect_clamp: assert property (
      rect_load && !clip_en && dx1[15] |=> rect_out.valid && rect_out.x1 == 16'h0)
      else $error("negative x not clamped");
   a_rect_skip: assert property (
      rect_load && dx2 <= dx1 |=> rect_out.valid && rect_out.skip) else $error("empty not skipped");
endmodule
bind copy_cmd_header_decoder copy_cmd_header_decoder_checker u_chk (
   .clk, .srst, .cmd_dword, .reg_wr, .reg_rd, .reg_addr, .reg_claim, .hdr_out, .mem_fetch_en,
   .reserved_flag, .rect_load, .clip_en, .dx1, .dx2, .rect_out, .img_rd, .img_idx, .front_ctx,
   .img_valid, .img_dword);
`default_nettype wire

// *** copy_cmd_header_decoder_test.sv ***
// Self-checking bench for the command header decoder
`default_nettype none
module copy_cmd_header_decoder_test import copy_cmd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, srst, ce, cmd_valid, cmd_nonsecure, cmd_ready, reg_wr, reg_rd, reg_priv, rc;
   logic reg_claim, inline_valid, mem_fetch_en, reserved_flag, rect_load, clip_en, img_rd;
   logic operand_tiled, operand_mono, img_valid, ctx_restore, fetch_seen, slow = 1'h0;
   logic [31:0] cmd_dword, reg_wdata, reg_rdata, inline_dword, front_ctx, img_dword, rq;
   logic [31:0] ctx_agent_mode, last_inl;
   logic [19:0] reg_addr;
   logic [15:0] pitch_dw;
   logic signed [15:0] dx1, dy1, dx2, dy2;
   logic [7:0]  img_idx;
   hdr_dec_s    hdr_out, hdr_seen;
   rect_s       rect_out, rs;
   int          n_fail = 0, checks = 0, n_hdr = 0, n_inl = 0;
   cmd_source u_src (.clk, .ready(cmd_ready), .slow, .valid(cmd_valid), .dword(cmd_dword));
   copy_cmd_header_decoder u_dut (.clk, .srst, .ce, .cmd_valid, .cmd_dword, .cmd_nonsecure,
      .cmd_ready, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_priv, .reg_claim, .reg_rdata,
      .hdr_out, .inline_valid, .inline_dword, .mem_fetch_en, .reserved_flag, .rect_load,
      .clip_en, .operand_tiled, .operand_mono, .pitch_dw, .dx1, .dy1, .dx2, .dy2, .rect_out,
      .img_rd, .img_idx, .front_ctx, .img_valid, .img_dword, .ctx_restore, .ctx_agent_mode);
   // Capture decoded headers and inline words as they stand
   always @(posedge clk) begin
      if (hdr_out.valid) begin
         hdr_seen <= hdr_out;
         fetch_seen <= mem_fetch_en;
         n_hdr <= n_hdr + 1;
      end
      if (inline_valid) begin
         last_inl <= inline_dword;
         n_inl <= n_inl + 1;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Queue a header with body words and wait for it to be decoded
   task automatic run_cmd(input logic [31:0] h, input int nb);
      int k, i;
      k = n_hdr;
      u_src.q.push_back(h);
      for (i = 0; i < nb; i++) u_src.q.push_back({16'hc0de, 16'(i)});
      for (i = 0; i < 60 && (n_hdr == k || u_src.q.size() > 0); i++) @(negedge clk);
      if (i == 60) begin
         n_fail++;
         complete_run();
      end
      repeat (2) @(negedge clk);
   endtask
   task automatic reg_cyc(input logic w, input logic [19:0] a, input logic [31:0] d);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
      @(negedge clk);
      {rc, rq} = {reg_claim, reg_rdata};
      {reg_wr, reg_rd} = 2'h0;
      @(negedge clk);
   endtask
   task automatic img_get(input logic [7:0] ix);
      {img_rd, img_idx} = {1'h1, ix};
      @(negedge clk);
      chk(img_valid, 1'h1);
      rq = img_dword;
      img_rd = 1'h0;
      @(negedge clk);
   endtask
   task automatic rect_t(input logic [63:0] c);
      {dx1, dy1, dx2, dy2, rect_load} = {c, 1'h1};
      @(negedge clk);
      rs = rect_out;
      rect_load = 1'h0;
      @(negedge clk);
   endtask
   task automatic t_blit_table();
      logic [6:0] ops [13] = '{7'h01, 7'h03, 7'h11, 7'h24, 7'h26, 7'h31, 7'h40, 7'h59, 7'h71,
                               7'h77, 7'h04, 7'h45, 7'h78};
      cmd_kind_e kd;
      foreach (ops[j]) begin
         kd = j < 3 ? KIND_SETUP : (j < 10 ? KIND_XFER : KIND_RESERVED);
         run_cmd({CLASS_BLT, ops[j], 13'h0a5a, 9'h000}, 0);
         chk(hdr_seen.kind, kd);
         chk(fetch_seen, kd == KIND_XFER);
         if (kd != KIND_RESERVED) chk({hdr_seen.opcode, hdr_seen.dep_data}, {ops[j], 13'h0a5a});
      end
      chk(reserved_flag, 1'h1);
   endtask
   task automatic t_stream();
      int k;
      slow = 1'h1;
      k = n_inl;
      run_cmd({CLASS_BLT, 7'h31, 13'h0, 9'h002}, 2);
      chk(32'(n_inl - k), 32'h2);
      chk(last_inl, 32'hc0de_0001);
      run_cmd({CLASS_HOST, MI_LRI_OP, 23'h000001}, 1);
      chk(hdr_seen.host_group, MI_GRP_STORE);
      chk(hdr_seen.dw_count, 9'h001);
      chk(last_inl, 32'hc0de_0000);
      run_cmd(NOOP_DW, 0);
      chk({hdr_seen.kind, hdr_seen.to_engine}, {KIND_HOST, 1'h0});
      slow = 1'h0;
   endtask
   task automatic t_regs();
      reg_cyc(1'h0, BUS_AGENT_ADDR, 32'h0);
      chk({rc, rq}, {1'h1, REG_RESET});
      reg_cyc(1'h1, BUS_AGENT_ADDR, 32'h1234_5678);
      reg_cyc(1'h0, BUS_AGENT_ADDR, 32'h0);
      chk(rq, 32'h1234_5678);
      reg_cyc(1'h1, SWCTRL_BASE + 20'h7c, 32'h0000_00a5);
      reg_cyc(1'h0, SWCTRL_BASE + 20'h7c, 32'h0);
      chk(rq, 32'h0000_00a5);
      reg_cyc(1'h1, GPR_BASE + 20'h7c, 32'h0000_005a);
      chk(rc, 1'h0);
      reg_cyc(1'h0, GPR_BASE, 32'h0);
      chk(rc, 1'h0);
      reg_cyc(1'h0, MMIO_HI - 20'h3, 32'h0);
      chk({rc, rq}, {1'h1, 32'h0});
      reg_cyc(1'h0, MMIO_LO - 20'h4, 32'h0);
      chk(rc, 1'h0);
      reg_cyc(1'h1, MMIO_LO, 32'h0);
      chk(reserved_flag, 1'h0);
      run_cmd({3'h1, 29'h0}, 0);
      chk({hdr_seen.kind, reserved_flag}, {KIND_RESERVED, 1'h1});
   endtask
   task automatic t_image();
      logic [7:0] ix [6] = '{8'h00, 8'hbf, PI_NOOP0, PI_LRI, PI_AGENT_A, PI_BBEND};
      logic [31:0] ex [6] = '{front_ctx, front_ctx, NOOP_DW, LRI_HEADER, {12'h0, BUS_AGENT_ADDR},
                              BBEND_DW};
      foreach (ix[j]) begin
         img_get(ix[j]);
         chk(rq, ex[j]);
      end
      {ctx_restore, ctx_agent_mode} = {1'h1, 32'h0bad_cafe};
      @(negedge clk);
      ctx_restore = 1'h0;
      img_get(PI_AGENT_D);
      chk(rq, 32'h0bad_cafe);
      reg_cyc(1'h0, BUS_AGENT_ADDR, 32'h0);
      chk(rq, 32'h0bad_cafe);
   endtask
   task automatic t_rect();
      run_cmd({CLASS_BLT, OP_LINEAR_B, 22'h0}, 0);
      chk(mem_fetch_en, 1'h1);
      rect_t({16'hfffb, 16'h0003, 16'h000a, 16'h0008});
      chk({rs.valid, rs.skip, rs.x1, rs.y1}, {2'h2, 16'h0000, 16'h0003});
      chk({rs.x2, rs.y2}, {16'h000a, 16'h0008});
      chk(rs.pitch_bytes, 18'h00040);
      rect_t({16'h0004, 16'h0003, 16'h0004, 16'h0008});
      chk({rs.skip, mem_fetch_en}, 2'h2);
      clip_en = 1'h1;
      rect_t({16'h0002, 16'h0002, 16'h0003, 16'h0003});
      chk(rs.skip, 1'h0);
   endtask
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   // Quiet inputs, reset for four cycles, then each scenario
   initial begin
      {srst, ce, cmd_nonsecure, reg_priv, operand_tiled, operand_mono} = 6'h38;
      {reg_wr, reg_rd, rect_load, clip_en, img_rd, ctx_restore} = 6'h0;
      {reg_addr, reg_wdata, img_idx, ctx_agent_mode} = 92'h0;
      {dx1, dy1, dx2, dy2, pitch_dw} = {64'h0, 16'h0010};
      front_ctx = 32'hfeed_0001;
      repeat (4) @(negedge clk);
      srst = 1'h0;
      @(negedge clk);
      chk(cmd_ready, 1'h1);
      t_blit_table();
      t_stream();
      t_regs();
      t_image();
      t_rect();
      complete_run();
   end
endmodule
`default_nettype wire
